// ---- hw/hbbl_host.sv ----
// host end: one word/byte access per request, strobes per scheme
// assumes the device answers reads within the strobe hold time
`timescale 1ns/1ns
`include "hbbl_consts.svh"
module hbbl_host import hbbl_pkg::*; #(
  parameter logic [3:0] HOLD = `HBBL_STROBE_HOLD
) (
  input  wire logic        i_clk,    // system clock
  input  wire logic        i_rst_n,  // sync reset
  input  wire logic [2:0]  i_scheme, // strobe scheme select
  input  wire logic        i_req,    // start access, pulse
  input  wire logic        i_we,     // write when high
  input  wire logic [1:0]  i_be,     // byte enables: [1] odd, [0] even
  input  wire logic [19:0] i_addr,   // byte address
  input  wire logic [15:0] i_wdata,  // write data, odd byte high
  output logic             o_busy,   // access in progress
  output logic             o_done,   // one-cycle completion
  output logic [15:0]      o_rdata,  // read data, odd byte high
  hbbl_if.host             bus       // device pins
);
  hbbl_state_t st_q;
  logic [3:0]  cnt_q;
  logic        we_q;
  logic [1:0]  be_q;
  logic [19:0] a_q;
  logic [15:0] wd_q;
  logic [15:0] rd_q;
  wire act = (st_q == HBBL_STRB);
  wire even_hi = (i_scheme == `HBBL_SCH_SIZ) || (i_scheme == `HBBL_SCH_UDLD)
              || (i_scheme == `HBBL_SCH_EB);
  wire bo = be_q[1]; // odd byte wanted
  wire bv = be_q[0]; // even byte wanted
  wire a0 = !bv;
  // burst host reads are code fetches on their own strobe
  wire fetch = (i_scheme == `HBBL_SCH_BURST);
  logic p0, p1, p2, p3;
  always_comb begin
    p0 = 1'b1; p1 = 1'b1; p2 = 1'b1; p3 = 1'b1;
    case (i_scheme)
      `HBBL_SCH_BHE: begin
        p0 = !(act && we_q); p1 = !(act && !we_q); p2 = !(act && bo);
      end
      `HBBL_SCH_SIZ: begin
        // size bit low means a word, high a single byte
        p0 = !we_q; p1 = !act; p2 = bo ^ bv;
      end
      `HBBL_SCH_UDLD, `HBBL_SCH_EB: begin
        p0 = !we_q; p1 = !(act && bv); p2 = !(act && bo);
      end
      default: begin
        p0 = !(act && we_q && bv); p3 = !(act && we_q && bo);
        p1 = !(act && !we_q && !fetch);
        p2 = !(act && !we_q && fetch);
      end
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q  <= HBBL_IDLE;
      cnt_q <= 4'h0;
      we_q  <= 1'b0;
      be_q  <= 2'b00;
      a_q   <= 20'h0_0000;
      wd_q  <= 16'h0000;
      rd_q  <= 16'h0000;
    end else begin
      case (st_q)
        HBBL_IDLE: if (i_req) begin
          st_q <= HBBL_ADDR;
          we_q <= i_we;
          be_q <= i_be;
          a_q  <= i_addr;
          wd_q <= even_hi ? {i_wdata[7:0], i_wdata[15:8]} : i_wdata;
        end
        HBBL_ADDR: begin
          st_q  <= HBBL_STRB;
          cnt_q <= HOLD;
        end
        HBBL_STRB: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h0) begin
            st_q <= HBBL_DONE;
            rd_q <= even_hi ? {bus.dat_i[7:0], bus.dat_i[15:8]} : bus.dat_i;
          end
        end
        default: st_q <= HBBL_IDLE;
      endcase
    end
  end
  assign bus.control_pin_0       = p0;
  assign bus.control_pin_1       = p1;
  assign bus.control_pin_2       = p2;
  assign bus.port_d_pin_3        = p3;
  assign bus.address_strobe_line = !(st_q == HBBL_ADDR);
  assign bus.addr_o              = {a_q[15:1], a0};
  assign bus.addr_hi             = a_q[19:16];
  assign bus.host_dat_o          = wd_q;
  assign bus.host_dat_oe         = we_q && (st_q != HBBL_IDLE) && (st_q != HBBL_DONE);
  assign o_busy                  = st_q != HBBL_IDLE;
  assign o_done                  = st_q == HBBL_DONE;
  assign o_rdata                 = rd_q;
endmodule

// ---- inc/hbbl_consts.svh ----
// constants for the host byte-lane bus: scheme codes, widths, timing
// assumes inclusion from the package and both end modules
`ifndef HBBL_CONSTS_SVH
`define HBBL_CONSTS_SVH
`define HBBL_SCH_BHE      3'h0
`define HBBL_SCH_WRHL     3'h1
`define HBBL_SCH_SIZ      3'h2
`define HBBL_SCH_UDLD     3'h3
`define HBBL_SCH_BURST    3'h4
`define HBBL_SCH_EB       3'h5
`define HBBL_SCH_OEWR     3'h6
`define HBBL_ADDR_W       20
`define HBBL_MEM_AW       8
`define HBBL_STROBE_HOLD  4'h2
`endif

// ---- inc/hbbl_pkg.sv ----
// types shared by both ends of the host byte-lane bus
// assumes the constants header is on the include path
`include "hbbl_consts.svh"
package hbbl_pkg;
  typedef enum logic [1:0] {
    HBBL_IDLE  = 2'b00,
    HBBL_ADDR  = 2'b01,
    HBBL_STRB  = 2'b11,
    HBBL_DONE  = 2'b10
  } hbbl_state_t;
endpackage

// ---- inc/hbbl_if.sv ----
// pins between host and device; active-low strobes, three-signal data pins
// assumes the bench resolves shared data from the enables
`timescale 1ns/1ns
interface hbbl_if;
  logic        control_pin_0;
  logic        control_pin_1;
  logic        control_pin_2;
  logic        port_d_pin_3;
  logic        address_strobe_line;
  logic [15:0] addr_o;
  logic [3:0]  addr_hi;
  logic [15:0] host_dat_o;
  logic        host_dat_oe;
  logic [15:0] dev_dat_o;
  logic        dev_dat_oe;
  logic [15:0] dat_i;
  modport device (input control_pin_0, control_pin_1, control_pin_2, port_d_pin_3,
                  address_strobe_line, addr_o, addr_hi, dat_i,
                  output dev_dat_o, dev_dat_oe);
  modport host (output control_pin_0, control_pin_1, control_pin_2, port_d_pin_3,
                address_strobe_line, addr_o, addr_hi, host_dat_o, host_dat_oe,
                input dat_i);
endinterface

// ---- hw/hbbl_device.sv ----
// device end: decodes strobes per scheme, holds a small byte memory
// assumes strobes synchronous to i_clk, scheme static while running
`timescale 1ns/1ns
`include "hbbl_consts.svh"
module hbbl_device import hbbl_pkg::*; #(
  parameter int AW = `HBBL_MEM_AW
) (
  input  wire logic       i_clk,     // system clock
  input  wire logic       i_rst_n,   // sync reset
  input  wire logic [2:0] i_scheme,  // strobe scheme select
  input  wire logic       i_muxed,   // shared address/data bus
  input  wire logic       i_sel,     // resource selected by decoder
  output logic [3:0]      o_addr_hi, // upper address for decoder
  hbbl_if.device          bus        // host pins
);
  logic [7:0]            mem_hi [2**(AW-1)];
  logic [7:0]            mem_lo [2**(AW-1)];
  logic [`HBBL_ADDR_W-1:0] lat_q;
  logic [15:0]           rd_q;
  logic                  oe_q;
  logic                  wr_prev_q;
  wire c0 = bus.control_pin_0;
  wire c1 = bus.control_pin_1;
  wire c2 = bus.control_pin_2;
  wire d3 = bus.port_d_pin_3;
  wire a0 = bus.addr_o[0];
  // latch upper bits on strobe when muxed, low four bits from the bus; else pass address through
  wire [`HBBL_ADDR_W-1:0] live = {bus.addr_hi, bus.addr_o};
  wire [`HBBL_ADDR_W-1:0] ea = i_muxed ?
       {lat_q[`HBBL_ADDR_W-1:4], bus.addr_o[3:0]} : live;
  // read and write decode per scheme; hi/lo mean upper/lower lane
  logic rd, wr, hi_en, lo_en, hi_odd;
  always_comb begin
    rd = 1'b0; wr = 1'b0; hi_en = 1'b0; lo_en = 1'b0; hi_odd = 1'b1;
    case (i_scheme)
      `HBBL_SCH_BHE: begin
        wr = !c0; rd = !c1;
        hi_en = !c2; lo_en = !a0;
      end
      `HBBL_SCH_WRHL, `HBBL_SCH_BURST, `HBBL_SCH_OEWR: begin
        wr = !c0 || !d3;
        rd = !c1 || (i_scheme == `HBBL_SCH_BURST && !c2);
        hi_en = rd ? 1'b1 : !d3; lo_en = rd ? 1'b1 : !c0;
      end
      `HBBL_SCH_SIZ: begin
        hi_odd = 1'b0;
        rd = !c1 && c0; wr = !c1 && !c0;
        hi_en = !a0; lo_en = !c2 || a0;
      end
      `HBBL_SCH_UDLD, `HBBL_SCH_EB: begin
        hi_odd = 1'b0;
        rd = c0 && (!c1 || !c2); wr = !c0 && (!c1 || !c2);
        hi_en = !c1; lo_en = !c2;
      end
      default: ;
    endcase
  end
  wire [AW-2:0] widx = ea[AW-1:1]; // a0 picks byte in the word
  wire acc = i_sel && (rd || wr);
  wire wr_edge = i_sel && wr && !wr_prev_q;
  // big-endian lanes put the even byte high; both memories swap roles
  wire [7:0] up_src = bus.dat_i[15:8];
  wire [7:0] lo_src = bus.dat_i[7:0];
  always_ff @(posedge i_clk) begin
    if (wr_edge && hi_en) begin
      if (hi_odd) mem_hi[widx] <= up_src;
      else        mem_lo[widx] <= up_src;
    end
    if (wr_edge && lo_en) begin
      if (hi_odd) mem_lo[widx] <= lo_src;
      else        mem_hi[widx] <= lo_src;
    end
  end
  // even byte = mem_lo, odd byte = mem_hi
  wire [15:0] rword = hi_odd ? {mem_hi[widx], mem_lo[widx]}
                             : {mem_lo[widx], mem_hi[widx]};
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lat_q     <= '0;
      rd_q      <= 16'h0000;
      oe_q      <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      if (!bus.address_strobe_line) lat_q <= live;
      rd_q      <= rword;
      oe_q      <= i_sel && rd;
      wr_prev_q <= acc && wr;
    end
  end
  assign bus.dev_dat_o  = rd_q;
  assign bus.dev_dat_oe = oe_q; // released unless read active
  assign o_addr_hi      = ea[`HBBL_ADDR_W-1:16];
endmodule

// ---- sim/hbbl_asserts.sv ----
// checker on the pins between host and device ends
// assumes active-low strobes and one access in flight at a time
`timescale 1ns/1ns
module hbbl_asserts (
  input wire logic        i_clk,               // system clock
  input wire logic        i_rst_n,             // sync reset
  input wire logic        control_pin_0,       // strobe pin 0
  input wire logic        control_pin_1,       // strobe pin 1
  input wire logic        control_pin_2,       // strobe pin 2
  input wire logic        port_d_pin_3,        // high write strobe
  input wire logic        address_strobe_line, // address latch strobe
  input wire logic [15:0] addr_o,              // low address
  input wire logic [3:0]  addr_hi,             // upper address
  input wire logic        host_dat_oe,         // host drives data
  input wire logic        dev_dat_oe           // device drives data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_stand3(logic s);
    !s[*3] ##1 s;
  endsequence
  a_no_contend: assert property (!(host_dat_oe && dev_dat_oe))
    else $error("both ends drive data");
  a_drive_on_read: assert property (dev_dat_oe |-> $past(!control_pin_1 || !control_pin_2))
    else $error("device drives without read strobe");
  a_oe_release: assert property ((control_pin_1 && control_pin_2)[*2] |-> !dev_dat_oe)
    else $error("device data not released");
  a_as_single: assert property (!address_strobe_line |=> address_strobe_line)
    else $error("address strobe longer than one cycle");
  a_strobe_after_as: assert property ($rose(address_strobe_line) |->
    (!control_pin_0 || !control_pin_1 || !control_pin_2 || !port_d_pin_3))
    else $error("no strobe after address phase");
  a_rd_width: assert property ($fell(control_pin_1) |-> s_stand3(control_pin_1))
    else $error("pin 1 strobe width wrong");
  a_wrh_width: assert property ($fell(port_d_pin_3) |-> s_stand3(port_d_pin_3))
    else $error("high write strobe width wrong");
  a_addr_stable: assert property (!control_pin_1 && $past(!control_pin_1) |->
    $stable(addr_o) && $stable(addr_hi))
    else $error("address moved under strobe");
endmodule

// ---- sim/host_bus_byte_lane_interface_tb.sv ----
// bench joining host and device ends: write word, write byte, read back
// assumes both ends share one clock; data wire resolved here
`timescale 1ns/1ns
module host_bus_byte_lane_interface_tb;
  import hbbl_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [2:0]  scheme = 3'h0;
  logic        muxed = 1'b0;
  logic        sel = 1'b0;
  logic        req = 1'b0;
  logic        we = 1'b0;
  logic [1:0]  be = 2'h0;
  logic [19:0] addr = 20'h0_0000;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] flt = 16'h5a5a;
  logic        busy;
  logic        done;
  logic [15:0] rdata;
  logic [3:0]  addr_hi;
  logic [20:0] exp_q[$];
  int          n_mismatch = 0;
  int          checks = 0;
  hbbl_if bus ();
  always #20 i_clk = ~i_clk;
  // released wire keeps changing so a stale value never matches
  always @(posedge i_clk) flt <= {flt[14:0], ~flt[15]};
  assign bus.dat_i = bus.dev_dat_oe ? bus.dev_dat_o : bus.host_dat_oe ? bus.host_dat_o : flt;
  hbbl_host i_hbbl_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scheme(scheme), .i_req(req),
    .i_we(we), .i_be(be), .i_addr(addr), .i_wdata(wdata), .o_busy(busy), .o_done(done),
    .o_rdata(rdata), .bus(bus.host));
  hbbl_device i_hbbl_device (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scheme(scheme),
    .i_muxed(muxed), .i_sel(sel), .o_addr_hi(addr_hi), .bus(bus.device));
  hbbl_asserts i_hbbl_asserts (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .control_pin_0(bus.control_pin_0), .control_pin_1(bus.control_pin_1),
    .control_pin_2(bus.control_pin_2), .port_d_pin_3(bus.port_d_pin_3),
    .address_strobe_line(bus.address_strobe_line), .addr_o(bus.addr_o),
    .addr_hi(bus.addr_hi), .host_dat_oe(bus.host_dat_oe), .dev_dat_oe(bus.dev_dat_oe));
  task cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t read data %h expected %h", $time, got, exp);
    end
  endtask
  task cmp4(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t upper address %h expected %h", $time, got, exp);
    end
  endtask
  task cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t busy %b expected %b", $time, got, exp);
    end
  endtask
  always @(posedge i_clk) begin
    if (done === 1'b1 && exp_q.size() > 0) begin
      cmp4(addr_hi, exp_q[0][20:17]);
      cmp1(busy, 1'b1);
      if (exp_q[0][16]) cmp16(rdata, exp_q[0][15:0]);
      void'(exp_q.pop_front());
    end
  end
  task acc(input logic w, input logic [1:0] b, input logic [19:0] a, input logic [15:0] d,
           input logic [16:0] ex);
    int k;
    exp_q.push_back({a[19:16], ex});
    we <= w;
    be <= b;
    addr <= a;
    wdata <= d;
    req <= 1'b1;
    @(posedge i_clk);
    req <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 50) begin
      @(posedge i_clk);
      k++;
    end
    // a hung access is a mismatch and ends the run here
    if (done !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t access never completed", $time);
      results;
    end else
      @(posedge i_clk);
  endtask
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    results;
  end
  initial begin
    logic [19:0] a;
    logic [15:0] wd;
    logic [15:0] bd;
    logic [15:0] w;
    logic [1:0]  b;
    void'($urandom(32'h8fa8));
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    sel <= 1'b1;
    @(posedge i_clk);
    // every scheme, latched and direct address, upper bits random
    for (int r = 0; r < 2; r++) begin
      for (int s = 0; s < 7; s++) begin
        scheme <= s[2:0];
        muxed <= r[0];
        a = {4'($urandom_range(15, 0)), 8'h00, 1'b0, r[0], s[2:0], 3'b000};
        wd = 16'($urandom);
        bd = 16'($urandom);
        b = 2'($urandom_range(3, 1));
        w = wd;
        if (b[0]) w[7:0] = bd[7:0];
        if (b[1]) w[15:8] = bd[15:8];
        acc(1'b1, 2'b11, a, wd, 17'h0_0000);
        acc(1'b1, b, a | {19'h0_0000, b == 2'b10}, bd, 17'h0_0000);
        // deselected write must leave the word alone
        sel <= 1'b0;
        acc(1'b1, 2'b11, a, ~w, 17'h0_0000);
        sel <= 1'b1;
        acc(1'b0, 2'b11, a, 16'h0000, {1'b1, w});
      end
    end
    repeat (4) @(posedge i_clk);
    results;
  end
endmodule
